/* verilog/olm_defs.svh */
`ifndef OLM_DEFS_SVH
`define OLM_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OLM_MCLK_HZ        200000000
`define OLM_INIT_TIME_MS   2000
`define OLM_INIT_CYC       (`OLM_INIT_TIME_MS * (`OLM_MCLK_HZ / 1000))
`define OLM_RST_MIN_NS     10000
`define OLM_RST_MIN_CYC    ((`OLM_RST_MIN_NS * (`OLM_MCLK_HZ / 1000000) + 999) / 1000)

// ----------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------
`define OLM_LANES          4
`define OLM_MON_W          16
`define OLM_MEM_DEPTH      16
`define OLM_SLAVE_ADDR     7'h50
`define OLM_LOS_THR_RST    16'h0100
`define OLM_PIN_IDLE       7'h73

// ----------------------------------------------------------------
// Register bus offsets and fields
// ----------------------------------------------------------------
`define OLM_REG_CTRL       8'h00
`define OLM_REG_STATUS     8'h04
`define OLM_REG_IRQ_STAT   8'h08
`define OLM_REG_IRQ_MASK   8'h0c
`define OLM_REG_LOS_THR    8'h10
`define OLM_REG_MON_HI     4'h2
`define OLM_CTRL_TXDIS     0
`define OLM_ST_NOT_READY   0
`define OLM_ST_LOW_PWR     1
`define OLM_ST_TX_OFF      2
`define OLM_ST_SELECTED    3
`define OLM_ST_LOS_LSB     4
`define OLM_ST_INT_LINE    8
`define OLM_EV_DONE        0
`define OLM_EV_LOS         1
`define OLM_EV_SER_WR      2
`define OLM_EV_W           3

// ----------------------------------------------------------------
// Serial memory map
// ----------------------------------------------------------------
`define OLM_SER_STATUS     4'h0
`define OLM_SER_FLAGS      8'h01
`define OLM_SER_CTRL       8'h0c
`define OLM_SER_MEM_PAGE   4'h1
`define OLM_SER_TXDIS      0

`endif

/* verilog/olm_pkg.sv */
package olm_pkg;

    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_WPTR,
        I2C_WDATA,
        I2C_ACK,
        I2C_RDATA,
        I2C_RACK
    } olm_i2c_state_t;

endpackage

/* verilog/olm_byte_mem.sv */
module olm_byte_mem #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16,
    parameter int unsigned AW    = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rstN,
    // Write port
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    // Registered read port
    input  wire logic [AW-1:0]    raddr,
    output logic      [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem [DEPTH];

    if (DEPTH < 2 || WIDTH < 1) begin : gBad
        $error("olm_byte_mem: DEPTH must be at least 2");
    end

    for (genvar i = 0; i < DEPTH; i++) begin : gEntry
        always_ff @(posedge clk) begin
            if (we && waddr == AW'(i)) begin
                mem[i] <= wdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            rdata <= '0;
        end else begin
            rdata <= mem[raddr];
        end
    end

endmodule

/* verilog/olm_mgmt.sv */
// Chosen here: the address map and register access over AHB-Lite.
`include "olm_defs.svh"

// Contract
// RULE1: Serial traffic is answered only while module select is held low.
// RULE2: A host sharing one serial bus gives every module its own select line.
// RULE3: A reset input held low past the minimum length restores all settings; ahbTxDis, irqMask and losThresh on AHB-Lite keep their values.
// RULE4: The host disregards status bits until reset completion is signalled.
// RULE5: Reset completion pulls the interrupt line and clears the not-ready flag.
// RULE6: After power-up the completion interrupt is posted without any reset.
// RULE7: The interrupt line goes low for a fault or a status critical to the host.
// RULE8: The host reads the serial memory map to find the interrupt source.
// RULE9: The interrupt line is only pulled low or released, never driven high.
// RULE10: The transmitter is off when disabled by the pin or a serial command.
// RULE11: The loss alarm rises when any of the four lane levels is below threshold.
// RULE12: Each lane level is monitored and readable over the serial bus.
// RULE13: Power consumption is limited by the low power select input.
// RULE14: The presence line is held low while the module is inserted.
// RULE15: The module is fully functional within the initialization time.
// RULE16: The reset input is filtered against a configurable minimum low time.
module olm_mgmt #(
    parameter int unsigned INIT_CYCLES = `OLM_INIT_CYC,
    parameter int unsigned RST_MIN_CYC = `OLM_RST_MIN_CYC,
    parameter logic [6:0]  SLAVE_ADDR  = `OLM_SLAVE_ADDR
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        nrst,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic      [31:0] hrdata,
    output logic             hresp,
    output logic             irq,
    // Host control pins
    input  wire logic        module_select_n,
    input  wire logic        module_reset_n,
    input  wire logic        low_power_select,
    input  wire logic        transmit_disable,
    // Serial bus
    input  wire logic        scl,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOeN,
    // Status pins
    input  wire logic        interrupt_n_in,
    output logic             interrupt_n_out,
    output logic             interrupt_n_oe_n,
    output logic             presence_n,
    // Lane levels and controls
    input  wire logic [63:0] rxLevel,
    output logic             txOff,
    output logic             powerLimitLow,
    output logic             receive_signal_loss_alarm
);
    import olm_pkg::*;

    localparam int unsigned LANES = `OLM_LANES;
    localparam int unsigned MW    = `OLM_MON_W;

    if (INIT_CYCLES < 1 || RST_MIN_CYC < 1 || RST_MIN_CYC > 65535) begin : gBad
        $error("olm_mgmt: INIT_CYCLES or RST_MIN_CYC out of range");
    end

    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic       rstMeta;
    logic       rstN;
    logic [6:0] pinMeta;
    logic [6:0] pinSync;
    logic [6:0] pinPrev;
    wire  [6:0] pinRaw = {interrupt_n_in, sdaIn, scl, transmit_disable,
                          low_power_select, module_reset_n, module_select_n};

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            pinMeta <= `OLM_PIN_IDLE;
            pinSync <= `OLM_PIN_IDLE;
            pinPrev <= `OLM_PIN_IDLE;
        end else begin
            pinMeta <= pinRaw;
            pinSync <= pinMeta;
            pinPrev <= pinSync;
        end
    end

    wire selActive = ~pinSync[0];
    wire rstPinLow = ~pinSync[1];
    wire lowPwrS   = pinSync[2];
    wire txDisS    = pinSync[3];
    wire sclS      = pinSync[4];
    wire sdaS      = pinSync[5];
    wire intLineS  = pinSync[6];
    wire sclRise   = sclS & ~pinPrev[4];
    wire sclFall   = ~sclS & pinPrev[4];
    wire startCond = sclS & pinPrev[4] & ~sdaS & pinPrev[5];
    wire stopCond  = sclS & pinPrev[4] & sdaS & ~pinPrev[5];

    // ----------------------------------------------------------------
    // Reset filter and initialization timer
    // ----------------------------------------------------------------
    logic [15:0] rstLowCnt;
    logic [31:0] initCnt;
    logic        dataNotReady;
    wire         modRstHeld = (rstLowCnt == 16'(RST_MIN_CYC));
    wire         initLast   = (initCnt == 32'(INIT_CYCLES - 1));
    wire         initDone   = dataNotReady & ~modRstHeld & initLast;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rstLowCnt <= 16'h0000;
        end else if (!rstPinLow) begin
            rstLowCnt <= 16'h0000; // RULE16
        end else if (!modRstHeld) begin
            rstLowCnt <= rstLowCnt + 16'h0001; // RULE16
        end
    end

    // Power-up leaves the not-ready flag set, so completion is posted unasked.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            dataNotReady <= 1'b1; // RULE6
            initCnt      <= 32'h0000_0000;
        end else if (modRstHeld) begin
            dataNotReady <= 1'b1; // RULE3
            initCnt      <= 32'h0000_0000;
        end else if (initDone) begin
            dataNotReady <= 1'b0; // RULE5 RULE15
            initCnt      <= 32'h0000_0000;
        end else if (dataNotReady) begin
            initCnt <= initCnt + 32'h0000_0001;
        end
    end

    // ----------------------------------------------------------------
    // Lane monitoring and serial map contents
    // ----------------------------------------------------------------
    logic [15:0] losThresh;
    logic [3:0]  losCmp;
    logic [3:0]  losR;
    logic [4:0]  serFlags;
    logic [7:0]  serialCtrl;
    logic [7:0]  liveBytes [16];
    logic [7:0]  memRd;
    logic [7:0]  ptr;
    wire  [3:0]  losNew = losCmp & ~losR;

    for (genvar g = 0; g < LANES; g++) begin : gLane
        assign losCmp[g]           = rxLevel[g*MW +: MW] < losThresh; // RULE11
        assign liveBytes[2 + 2*g]  = rxLevel[g*MW + 8 +: 8]; // RULE12
        assign liveBytes[3 + 2*g]  = rxLevel[g*MW +: 8]; // RULE12
    end

    assign liveBytes[0]  = {5'h00, powerLimitLow, txOff, dataNotReady};
    assign liveBytes[1]  = {3'h0, serFlags};
    assign liveBytes[10] = 8'h00;
    assign liveBytes[11] = 8'h00;
    assign liveBytes[12] = serialCtrl;
    assign liveBytes[13] = 8'h00;
    assign liveBytes[14] = 8'h00;
    assign liveBytes[15] = 8'h00;

    wire [7:0] rdByte = (ptr[7:4] == `OLM_SER_STATUS)   ? liveBytes[ptr[3:0]] :
                        (ptr[7:4] == `OLM_SER_MEM_PAGE) ? memRd : 8'h00;

    // ----------------------------------------------------------------
    // Serial bus slave
    // ----------------------------------------------------------------
    olm_i2c_state_t i2cState;
    olm_i2c_state_t rxNext;
    logic [3:0]     bitCnt;
    logic [7:0]     shiftIn;
    logic [7:0]     txByte;
    logic           ackToRead;
    logic           masterAck;

    wire byteDone = sclFall & (bitCnt == 4'h8);
    wire loadRd   = sclFall & ((i2cState == I2C_ACK && ackToRead) ||
                               (i2cState == I2C_RACK && masterAck));
    wire serWrite = byteDone & (i2cState == I2C_WDATA);
    wire memWe    = serWrite & (ptr[7:4] == `OLM_SER_MEM_PAGE);
    wire ctrlWe   = serWrite & (ptr == `OLM_SER_CTRL);
    wire flagRead = loadRd & (ptr == `OLM_SER_FLAGS);
    wire addrHit  = (shiftIn[7:1] == SLAVE_ADDR);

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            i2cState  <= I2C_IDLE;
            rxNext    <= I2C_WPTR;
            bitCnt    <= 4'h0;
            shiftIn   <= 8'h00;
            txByte    <= 8'hff;
            ptr       <= 8'h00;
            ackToRead <= 1'b0;
            masterAck <= 1'b0;
            sdaOeN    <= 1'b1;
        end else if (!selActive || stopCond) begin
            i2cState <= I2C_IDLE; // RULE1
            sdaOeN   <= 1'b1; // RULE1
        end else if (startCond) begin
            i2cState <= I2C_ADDR;
            bitCnt   <= 4'h0;
            sdaOeN   <= 1'b1;
        end else if (loadRd) begin
            txByte   <= rdByte;
            sdaOeN   <= rdByte[7];
            ptr      <= ptr + 8'h01;
            bitCnt   <= 4'h0;
            i2cState <= I2C_RDATA;
        end else begin
            case (i2cState)
                I2C_ADDR, I2C_WPTR, I2C_WDATA: begin
                    if (sclRise) begin
                        shiftIn <= {shiftIn[6:0], sdaS};
                        bitCnt  <= bitCnt + 4'h1;
                    end else if (byteDone) begin
                        bitCnt <= 4'h0;
                        if (i2cState == I2C_ADDR && !addrHit) begin
                            i2cState <= I2C_IDLE;
                        end else begin
                            sdaOeN    <= 1'b0;
                            i2cState  <= I2C_ACK;
                            ackToRead <= (i2cState == I2C_ADDR) & shiftIn[0];
                            rxNext    <= (i2cState == I2C_ADDR) ? I2C_WPTR : I2C_WDATA;
                            if (i2cState == I2C_WPTR) begin
                                ptr <= shiftIn;
                            end else if (i2cState == I2C_WDATA) begin
                                ptr <= ptr + 8'h01;
                            end
                        end
                    end
                end
                I2C_ACK: begin
                    if (sclFall) begin
                        sdaOeN   <= 1'b1;
                        i2cState <= rxNext;
                    end
                end
                I2C_RDATA: begin
                    if (sclRise) begin
                        bitCnt <= bitCnt + 4'h1;
                    end else if (byteDone) begin
                        sdaOeN    <= 1'b1;
                        bitCnt    <= 4'h0;
                        masterAck <= 1'b0;
                        i2cState  <= I2C_RACK;
                    end else if (sclFall) begin
                        txByte <= {txByte[6:0], 1'b1};
                        sdaOeN <= txByte[6];
                    end
                end
                I2C_RACK: begin
                    if (sclRise) begin
                        masterAck <= ~sdaS;
                    end else if (sclFall) begin
                        i2cState <= I2C_IDLE;
                    end
                end
                default: begin
                    i2cState <= I2C_IDLE;
                end
            endcase
        end
    end

    olm_byte_mem #(
        .WIDTH (8),
        .DEPTH (`OLM_MEM_DEPTH)
    ) uMem (
        .clk   (mclk),
        .rstN  (rstN),
        .we    (memWe),
        .waddr (ptr[3:0]),
        .wdata (shiftIn),
        .raddr (ptr[3:0]),
        .rdata (memRd)
    );

    // ----------------------------------------------------------------
    // Serial settings and host-visible flags
    // ----------------------------------------------------------------
    wire [4:0] serFlagsClr = flagRead ? 5'h1f : 5'h00;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            serialCtrl <= 8'h00;
            serFlags   <= 5'h00;
        end else if (modRstHeld) begin
            serialCtrl <= 8'h00; // RULE3
            serFlags   <= 5'h00; // RULE3
        end else begin
            if (ctrlWe) begin
                serialCtrl <= shiftIn;
            end
            serFlags <= (serFlags & ~serFlagsClr) | {losNew, initDone}; // RULE5 RULE7
        end
    end

    // ----------------------------------------------------------------
    // AHB-Lite register file
    // ----------------------------------------------------------------
    logic                 ahbTxDis;
    logic [`OLM_EV_W-1:0] irqStat;
    logic [`OLM_EV_W-1:0] irqMask;
    logic                 wrPend;
    logic [7:0]           wrAddr;

    wire        ahbAccess = hsel & hready & htrans[1];
    wire [7:0]  ra        = haddr[7:0];
    wire [15:0] monSel    = rxLevel[{ra[3:2], 4'h0} +: 16];
    wire [31:0] statusWord = {23'h0, intLineS, losR, selActive, txOff,
                              powerLimitLow, dataNotReady};
    wire [31:0] ahbRdVal =
        (ra == `OLM_REG_CTRL)     ? {31'h0, ahbTxDis} :
        (ra == `OLM_REG_STATUS)   ? statusWord :
        (ra == `OLM_REG_IRQ_STAT) ? {29'h0, irqStat} :
        (ra == `OLM_REG_IRQ_MASK) ? {29'h0, irqMask} :
        (ra == `OLM_REG_LOS_THR)  ? {16'h0, losThresh} :
        (ra[7:4] == `OLM_REG_MON_HI) ? {16'h0, monSel} : 32'h0; // RULE12
    wire wrCtrl = wrPend & (wrAddr == `OLM_REG_CTRL);
    wire wrStat = wrPend & (wrAddr == `OLM_REG_IRQ_STAT);
    wire wrMask = wrPend & (wrAddr == `OLM_REG_IRQ_MASK);
    wire wrThr  = wrPend & (wrAddr == `OLM_REG_LOS_THR);
    wire [`OLM_EV_W-1:0] events  = {serWrite, |losNew, initDone};
    wire [`OLM_EV_W-1:0] w1cMask = wrStat ? hwdata[`OLM_EV_W-1:0] : '0;

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wrPend <= ahbAccess & hwrite;
            wrAddr <= ra;
            hrdata <= (ahbAccess && !hwrite) ? ahbRdVal : 32'h0000_0000;
        end
    end

    // An event in the same cycle as its write-one-to-clear survives.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            ahbTxDis  <= 1'b0;
            irqMask   <= '0;
            irqStat   <= '0;
            losThresh <= `OLM_LOS_THR_RST;
        end else begin
            if (wrCtrl) ahbTxDis <= hwdata[`OLM_CTRL_TXDIS];
            if (wrMask) irqMask <= hwdata[`OLM_EV_W-1:0];
            if (wrThr)  losThresh <= hwdata[15:0];
            irqStat <= (irqStat & ~w1cMask) | events;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            hreadyout                 <= 1'b1;
            hresp                     <= 1'b0;
            irq                       <= 1'b0;
            losR                      <= 4'h0;
            txOff                     <= 1'b0;
            powerLimitLow             <= 1'b0;
            receive_signal_loss_alarm <= 1'b0;
            interrupt_n_out           <= 1'b0;
            interrupt_n_oe_n          <= 1'b1;
            presence_n                <= 1'b0;
            sdaOut                    <= 1'b0;
        end else begin
            hreadyout                 <= 1'b1;
            hresp                     <= 1'b0;
            irq                       <= |(irqStat & irqMask);
            losR                      <= losCmp;
            txOff                     <= txDisS | serialCtrl[`OLM_SER_TXDIS] | ahbTxDis; // RULE10
            powerLimitLow             <= lowPwrS; // RULE13
            receive_signal_loss_alarm <= |losCmp; // RULE11
            interrupt_n_out           <= 1'b0; // RULE9
            interrupt_n_oe_n          <= ~(|serFlags); // RULE7 RULE5
            presence_n                <= 1'b0; // RULE14
            sdaOut                    <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cbMain @(posedge mclk);
    endclocking
    default disable iff (!rstN);

    chk_sel_gates_bus: assert property (!selActive |=> sdaOeN) // RULE1
        else $error("serial data driven while not selected");
    chk_rst_filter_min: assert property (!rstPinLow |=> !modRstHeld) // RULE16
        else $error("module reset acted without a long enough low pulse");
    chk_reset_restores: assert property (modRstHeld |=>
        (dataNotReady && serialCtrl == 8'h00 && serFlags == 5'h00)) // RULE3
        else $error("module reset did not restore defaults");
    chk_done_posts_int: assert property (initDone |=> !dataNotReady ##1 !interrupt_n_oe_n) // RULE5
        else $error("reset completion did not pull the interrupt line");
    chk_power_up_done: assert property ($fell(dataNotReady) |-> $past(initLast)) // RULE6
        else $error("not ready cleared before the init time ran out");
    chk_fault_int_low: assert property ((|losNew && !modRstHeld) |-> ##2 !interrupt_n_oe_n) // RULE7
        else $error("lane loss did not pull the interrupt line");
    chk_int_open_drain: assert property (!interrupt_n_out) // RULE9
        else $error("interrupt line driven high");
    chk_tx_disable_or: assert property ((txDisS || serialCtrl[0] || ahbTxDis) |=> txOff) // RULE10
        else $error("transmitter not turned off when disabled");
    chk_los_alarm_any: assert property (receive_signal_loss_alarm == $past(|losCmp)) // RULE11
        else $error("loss alarm does not follow lane levels");
    chk_low_power_pin: assert property (powerLimitLow == $past(lowPwrS)) // RULE13
        else $error("power limit does not follow the select pin");
    chk_presence_low: assert property (!presence_n) // RULE14
        else $error("presence line released while inserted");
    chk_init_bounded: assert property (dataNotReady |-> initCnt < INIT_CYCLES) // RULE15
        else $error("initialization counter ran past its limit");

    cov_init_done:  cover property (initDone);
    cov_ser_write:  cover property (serWrite);
    cov_ser_read:   cover property (loadRd ##[1:400] loadRd);
    cov_los_event:  cover property (|losNew);

endmodule

/* dv/olm_host_model.sv */
`include "olm_defs.svh"
module olm_host_model (
    output logic      scl,
    output logic      sdaRelease,
    input  wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 100ps;
    // Clock and data rest high between frames.
    initial begin
        scl = 1'b1;
        sdaRelease = 1'b1;
    end
    task automatic bitOut(input logic b);
        sdaRelease = b;
        #31 scl = 1'b1;
        #63 scl = 1'b0;
        #31;
    endtask
    task automatic bitIn(output logic b);
        sdaRelease = 1'b1;
        #31 scl = 1'b1;
        #31 b = sdaLine;
        #32 scl = 1'b0;
        #31;
    endtask
    task automatic start();
        sdaRelease = 1'b1;
        #31 scl = 1'b1;
        #31 sdaRelease = 1'b0;
        #31 scl = 1'b0;
        #31;
    endtask
    task automatic byteOut(input logic [7:0] v, output logic ack);
        for (int i = 7; i >= 0; i--) bitOut(v[i]);
        bitIn(ack);
    endtask
    // Writes one byte at a pointer and ends the frame with a stop.
    task automatic writeAt(input logic [7:0] ptr, input logic [7:0] v, output logic ack);
        logic a2;
        start();
        byteOut({`OLM_SLAVE_ADDR, 1'b0}, a2);
        byteOut(ptr, a2);
        byteOut(v, ack);
        sdaRelease = 1'b0;
        #31 scl = 1'b1;
        #31 sdaRelease = 1'b1;
        #62;
    endtask
    // Source of an interrupt is found by reading the serial map.
    task automatic readAt(input logic [7:0] ptr, output logic ack, output logic [7:0] d);
        logic a2;
        start();
        byteOut({`OLM_SLAVE_ADDR, 1'b0}, ack);
        byteOut(ptr, a2);
        start();
        byteOut({`OLM_SLAVE_ADDR, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) bitIn(d[i]);
        bitOut(1'b1);
        sdaRelease = 1'b0;
        #31 scl = 1'b1;
        #31 sdaRelease = 1'b1;
        #62;
    endtask
endmodule

/* dv/optical_module_low_speed_mgmt_tb.sv */
`include "olm_defs.svh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module optical_module_low_speed_mgmt_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk, nrst, hwrite, hready, hresp, irq, modSelN, modRstN, lowPwr, txDis;
    logic        scl, sdaRel, sdaOut, sdaOeN, intOut, intOeN, presN, txOff, pwrLow, los;
    logic        ack;
    logic [1:0]  htrans;
    logic [7:0]  sd;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [63:0] rxLevel;
    int          fails = 0;
    int          tests_run = 0;
    wire         sdaLine = sdaRel & sdaOeN;
    wire         intLine = intOeN | intOut;
    olm_mgmt #(.INIT_CYCLES(200), .RST_MIN_CYC(8)) olm_mgmt_inst (
        .mclk(mclk), .nrst(nrst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .irq(irq),
        .module_select_n(modSelN), .module_reset_n(modRstN), .low_power_select(lowPwr),
        .transmit_disable(txDis), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOeN(sdaOeN), .interrupt_n_in(intLine), .interrupt_n_out(intOut),
        .interrupt_n_oe_n(intOeN), .presence_n(presN), .rxLevel(rxLevel), .txOff(txOff),
        .powerLimitLow(pwrLow), .receive_signal_loss_alarm(los));
    olm_host_model olm_host_model_inst (.scl(scl), .sdaRelease(sdaRel), .sdaLine(sdaLine));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic waitReady();
        int n;
        n = 0;
        do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 50);
        if (hready !== 1'b1) begin fails++; $display("[FAIL] %0t bus hang", $time); wrap_up(); end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        waitReady();
        htrans <= 2'h0;
        hwdata <= wd;
        waitReady();
        rd = hrdata;
    endtask
    task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic waitInt();
        int n;
        n = 0;
        while (intOeN !== 1'b0 && n < 600) begin @(posedge mclk); n++; end
        `CHK(intOeN, 1'b0)
        if (intOeN !== 1'b0) wrap_up();
        // The line level reaches the status word through two sync flops.
        hold(2);
    endtask
    task automatic hold(input int c);
        repeat (c) @(posedge mclk);
    endtask
    initial begin
        #200000 fails++;
        $display("[FAIL] %0t run hang", $time);
        wrap_up();
    end
    initial begin
        {nrst, htrans, haddr, hwrite, hwdata, lowPwr, txDis} = '0;
        modSelN = 1'b1;
        modRstN = 1'b1;
        rxLevel = {4{16'h0200}};
        hold(10);
        nrst <= 1'b1;
        hold(3);
        `CHK(presN, 1'b0)
        `CHK({hresp, sdaOut}, 2'h0)
        rdChk(`OLM_REG_CTRL, 32'h0);
        rdChk(32'h14, 32'h0);
        rdChk(`OLM_REG_LOS_THR, 32'h100);
        rdChk(`OLM_REG_STATUS, 32'h101);
        waitInt();
        `CHK(intOut, 1'b0)
        rdChk(`OLM_REG_STATUS, 32'h0);
        rdChk(`OLM_REG_IRQ_STAT, 32'h1);
        ahb(1'b1, `OLM_REG_IRQ_MASK, 32'h1);
        hold(2);
        `CHK(irq, 1'b1)
        ahb(1'b1, `OLM_REG_IRQ_STAT, 32'h1);
        hold(2);
        `CHK(irq, 1'b0)
        rxLevel <= {16'h0200, 16'h00ff, 16'h0100, 16'h0200};
        hold(4);
        `CHK(los, 1'b1)
        rdChk(`OLM_REG_STATUS, 32'h040);
        rdChk(32'h28, 32'h00ff);
        rxLevel <= {4{16'h0100}};
        hold(4);
        `CHK(los, 1'b0)
        ahb(1'b1, `OLM_REG_CTRL, 32'h1);
        hold(2);
        `CHK(txOff, 1'b1)
        ahb(1'b1, `OLM_REG_CTRL, 32'h0);
        txDis <= 1'b1;
        lowPwr <= 1'b1;
        modSelN <= 1'b0;
        hold(6);
        `CHK(txOff, 1'b1)
        `CHK(pwrLow, 1'b1)
        olm_host_model_inst.readAt(8'h00, ack, sd);
        `CHK(ack, 1'b0)
        `CHK(sd, 8'h06)
        olm_host_model_inst.readAt(8'h06, ack, sd);
        `CHK(sd, 8'h01)
        olm_host_model_inst.readAt(8'h01, ack, sd);
        `CHK(sd, 8'h09)
        olm_host_model_inst.writeAt(8'h0c, 8'h01, ack);
        `CHK(ack, 1'b0)
        hold(1);
        txDis <= 1'b0;
        hold(6);
        `CHK(txOff, 1'b1)
        modSelN <= 1'b1;
        hold(4);
        olm_host_model_inst.readAt(8'h00, ack, sd);
        `CHK(ack, 1'b1)
        hold(1);
        modRstN <= 1'b0;
        hold(4);
        modRstN <= 1'b1;
        hold(6);
        rdChk(`OLM_REG_STATUS, 32'h106);
        modRstN <= 1'b0;
        hold(20);
        rdChk(`OLM_REG_STATUS, 32'h103);
        modRstN <= 1'b1;
        waitInt();
        rdChk(`OLM_REG_STATUS, 32'h002);
        wrap_up();
    end
endmodule
